// ==== core/wmcc_core.sv ====
// Wake-up, mode selection, configuration and nonvolatile control core with a Wishbone slave.
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module wmcc_core #(
	parameter int TE_CYC  = wmcc_pkg::TE_CYC,
	parameter int TE_STEP = wmcc_pkg::TE_STEP_CYC
) (
	input  logic        clk_i,
	input  logic        rst_i,
	input  logic [7:0]  wb_adr_i,
	input  logic [31:0] wb_dat_i,
	input  logic [3:0]  wb_sel_i,
	input  logic        wb_we_i,
	input  logic        wb_cyc_i,
	input  logic        wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic        wb_ack_o,
	input  logic        button_in_first_i,
	input  logic        button_in_second_i,
	input  logic        shared_button_rf_coil_pin_i,
	output logic        shared_button_rf_coil_pin_o,
	output logic        shared_button_rf_coil_pin_oe_n_o,
	input  logic        coil_input_pin_i,
	input  logic        data_pin_i,
	output logic        data_pin_o,
	output logic        data_pin_oe_n_o,
	input  logic        lowbat_below_2v2_i,
	input  logic        lowbat_below_4v4_i,
	input  logic        nvm_vpp_ok_i,
	output logic        led_o,
	output logic        main_power_o,
	output logic        encoder_mode_o,
	output logic        transponder_mode_o,
	output logic        low_battery_flag_o,
	output logic        coil_if_en_o,
	output logic [3:0]  osc_trim_field_o
);

	// ****************************************
	// Declarations
	// ****************************************
	wmcc_pkg::wmcc_state_t state_reg;
	logic [15:0] nvm_mem [wmcc_pkg::NVM_WORDS];
	logic [15:0] cfg_reg;
	logic        cfg_loaded_reg;
	logic [1:0]  ctrl_reg;
	logic [2:0]  nvm_idx_reg;
	logic [3:0]  btn_stat_reg;
	logic [31:0] shift_reg;
	logic [4:0]  bit_cnt_reg;
	logic        phase_reg;
	logic [1:0]  step_reg;
	logic [15:0] te_cnt_reg;
	logic        te_pulse_reg;
	logic        prog_clk_d_reg;
	logic [3:0]  prog_bits_reg;
	logic [2:0]  prog_idx_reg;
	logic        ack_reg;
	logic [31:0] dat_reg;
	logic [31:0] rd_mux;
	logic [7:0]  pin_raw;
	logic [7:0]  pin_s;
	logic        pinsel_eff;
	logic        btn_any;
	logic        coil_act;
	logic        wake_src;
	logic        prog_en;
	logic        prog_rd;
	logic        lb_now;
	logic        vpp;
	logic        wb_req;
	logic        tx_last;
	logic        prog_rise;
	logic [2:0]  prog_nidx;
	logic [15:0] prog_rd_word;
	logic [15:0] cnt_bin;
	logic [15:0] cnt_gray_next;
	logic [31:0] tx_word;
	logic [15:0] te_reload;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	assign pin_raw = {nvm_vpp_ok_i, lowbat_below_4v4_i, lowbat_below_2v2_i, data_pin_i,
		coil_input_pin_i, shared_button_rf_coil_pin_i, button_in_second_i,
		button_in_first_i};

	wmcc_sync3 #(
		.WIDTH(8)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i  (pin_raw),
		.q_o  (pin_s)
	);

	// ****************************************
	// Wake sources and derived terms
	// ****************************************
	// Until the configuration has loaded the third pin is never taken as a button.
	assign pinsel_eff = cfg_loaded_reg & cfg_reg[wmcc_pkg::CFG_PINSEL];
	assign btn_any    = pin_s[0] | pin_s[1] | (pinsel_eff & pin_s[2]);
	assign coil_act   = ~pinsel_eff & pin_s[3];
	assign wake_src   = btn_any | coil_act;
	assign prog_en    = ctrl_reg[wmcc_pkg::CTRL_PROG_EN];
	assign prog_rd    = ctrl_reg[wmcc_pkg::CTRL_PROG_RD];
	assign lb_now     = cfg_reg[wmcc_pkg::CFG_VSEL] ? pin_s[6] : pin_s[5];
	assign vpp        = pin_s[7];
	assign wb_req     = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign tx_last    = &bit_cnt_reg;
	assign prog_rise  = (state_reg == wmcc_pkg::ST_PROG) & pin_s[2] & ~prog_clk_d_reg;
	assign prog_nidx  = prog_idx_reg + 3'h1;
	// Secret words shift out as zeros.
	assign prog_rd_word = (prog_nidx >= wmcc_pkg::NVM_USER0) ? nvm_mem[prog_nidx] : 16'h0000;
	assign cnt_bin       = wmcc_pkg::gray2bin(nvm_mem[wmcc_pkg::NVM_CNT]);
	assign cnt_gray_next = wmcc_pkg::bin2gray(cnt_bin + 16'h0001);
	// Frame: low-battery flag, button status, padding, binary counter.
	assign tx_word = {lb_now, btn_stat_reg, 11'h000, cnt_bin};
	// Signed trim: positive codes lengthen the element, 1000b gives the shortest.
	assign te_reload = 16'(TE_CYC + int'($signed(cfg_reg[3:0])) * TE_STEP - 1);

	// ****************************************
	// Main sequencer
	// ****************************************
	// One machine sequences wake, load, count, send and programming.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= wmcc_pkg::ST_STANDBY;
			step_reg  <= 2'h0;
		end else begin
			case (state_reg)
				wmcc_pkg::ST_STANDBY: begin
					if (prog_en) begin
						state_reg <= wmcc_pkg::ST_PROG;
					end else if (wake_src) begin
						state_reg <= wmcc_pkg::ST_WAKE;
					end
				end
				wmcc_pkg::ST_WAKE: begin
					state_reg <= cfg_loaded_reg ? wmcc_pkg::ST_DECIDE : wmcc_pkg::ST_CFGLD;
				end
				wmcc_pkg::ST_CFGLD: begin
					state_reg <= wmcc_pkg::ST_DECIDE;
				end
				wmcc_pkg::ST_DECIDE: begin
					if (btn_any) begin
						state_reg <= wmcc_pkg::ST_COUNT;
					end else if (coil_act) begin
						state_reg <= wmcc_pkg::ST_XPOND;
					end else begin
						state_reg <= wmcc_pkg::ST_STANDBY;
					end
				end
				wmcc_pkg::ST_COUNT: begin
					// Each step waits for adequate write voltage.
					if (vpp) begin
						if (step_reg == wmcc_pkg::CNT_STEPS) begin
							step_reg  <= 2'h0;
							state_reg <= wmcc_pkg::ST_SEND;
						end else begin
							step_reg <= step_reg + 2'h1;
						end
					end
				end
				wmcc_pkg::ST_SEND: begin
					if (te_pulse_reg && phase_reg && tx_last && !btn_any) begin
						state_reg <= coil_act ? wmcc_pkg::ST_DECIDE : wmcc_pkg::ST_STANDBY;
					end
				end
				wmcc_pkg::ST_XPOND: begin
					if (btn_any) begin
						state_reg <= wmcc_pkg::ST_DECIDE;
					end else if (!coil_act) begin
						state_reg <= wmcc_pkg::ST_STANDBY;
					end
				end
				wmcc_pkg::ST_PROG: begin
					if (!prog_en) begin
						state_reg <= wmcc_pkg::ST_STANDBY;
					end
				end
				default: begin
					state_reg <= wmcc_pkg::ST_STANDBY;
				end
			endcase
		end
	end

	// Configuration is fetched once; later activations reuse it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg        <= wmcc_pkg::CFG_RST;
			cfg_loaded_reg <= 1'b0;
		end else if (state_reg == wmcc_pkg::ST_CFGLD) begin
			cfg_reg        <= nvm_mem[wmcc_pkg::NVM_CFG];
			cfg_loaded_reg <= 1'b1;
		end
	end

	// Timer of basic time elements, stopped in standby to save power.
	always_ff @(posedge clk_i) begin
		if (rst_i || state_reg == wmcc_pkg::ST_STANDBY) begin
			te_cnt_reg   <= 16'h0000;
			te_pulse_reg <= 1'b0;
		end else if (te_cnt_reg == 16'h0000) begin
			te_cnt_reg   <= te_reload;
			te_pulse_reg <= 1'b1;
		end else begin
			te_cnt_reg   <= te_cnt_reg - 16'h0001;
			te_pulse_reg <= 1'b0;
		end
	end

	// ****************************************
	// Shared shift register
	// ****************************************
	// The same 32 bits carry the code word and the programming data.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shift_reg    <= 32'h0000_0000;
			bit_cnt_reg  <= 5'h00;
			phase_reg    <= 1'b0;
			btn_stat_reg <= 4'h0;
		end else if (state_reg == wmcc_pkg::ST_DECIDE) begin
			btn_stat_reg <= {coil_act, pinsel_eff & pin_s[2], pin_s[1], pin_s[0]};
			bit_cnt_reg  <= 5'h00;
			phase_reg    <= 1'b0;
		end else if (state_reg == wmcc_pkg::ST_COUNT) begin
			shift_reg <= tx_word;
		end else if (state_reg == wmcc_pkg::ST_SEND && te_pulse_reg) begin
			phase_reg <= ~phase_reg;
			if (phase_reg) begin
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
				shift_reg   <= tx_last ? tx_word : {shift_reg[30:0], 1'b0};
			end
		end else if (state_reg == wmcc_pkg::ST_STANDBY) begin
			shift_reg <= 32'h0000_0000;
		end else if (prog_rise) begin
			if (prog_rd) begin
				shift_reg <= (prog_bits_reg == wmcc_pkg::PROG_LAST) ? {16'h0000, prog_rd_word}
					: {shift_reg[30:0], 1'b0};
			end else begin
				shift_reg <= {shift_reg[30:0], pin_s[4]};
			end
		end
	end

	// Programming bit and word counters, cleared outside programming.
	always_ff @(posedge clk_i) begin
		prog_clk_d_reg <= pin_s[2];
		if (rst_i || state_reg != wmcc_pkg::ST_PROG) begin
			prog_bits_reg <= 4'h0;
			prog_idx_reg  <= 3'h0;
		end else if (prog_rise) begin
			prog_bits_reg <= prog_bits_reg + 4'h1;
			if (prog_bits_reg == wmcc_pkg::PROG_LAST) begin
				prog_idx_reg <= prog_nidx;
			end
		end
	end

	// ****************************************
	// Nonvolatile storage
	// ****************************************
	// The counter changes by one gray step, so only one bit is rewritten per update.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < wmcc_pkg::NVM_WORDS; i++) begin
				nvm_mem[i] <= 16'h0000;
			end
		end else if (state_reg == wmcc_pkg::ST_COUNT && vpp) begin
			case (step_reg)
				2'h0: nvm_mem[wmcc_pkg::NVM_SEM] <= wmcc_pkg::SEM_BUSY;
				2'h1: nvm_mem[wmcc_pkg::NVM_CNT] <= cnt_gray_next;
				default: nvm_mem[wmcc_pkg::NVM_SEM] <= wmcc_pkg::SEM_IDLE;
			endcase
		end else if (prog_rise && !prog_rd && vpp && prog_bits_reg == wmcc_pkg::PROG_LAST) begin
			nvm_mem[prog_idx_reg] <= {shift_reg[14:0], pin_s[4]};
		end else if (wb_req && wb_we_i && wb_adr_i == wmcc_pkg::ADR_NVM_DATA && vpp
			&& nvm_idx_reg >= wmcc_pkg::NVM_USER0) begin
			nvm_mem[nvm_idx_reg] <= wb_dat_i[15:0];
		end
	end

	// ****************************************
	// Wishbone slave
	// ****************************************
	// Control and index writes; the request cycle acts, ack follows next cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg    <= wmcc_pkg::CTRL_RST;
			nvm_idx_reg <= 3'h0;
		end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == wmcc_pkg::ADR_CTRL) begin
				ctrl_reg <= wb_dat_i[1:0];
			end else if (wb_adr_i == wmcc_pkg::ADR_NVM_IDX) begin
				nvm_idx_reg <= wb_dat_i[2:0];
			end
		end
	end

	// Read decode; unmapped addresses and secret words read zero.
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (wb_adr_i == wmcc_pkg::ADR_CTRL) begin
			rd_mux = {30'h0, ctrl_reg};
		end else if (wb_adr_i == wmcc_pkg::ADR_STATUS) begin
			rd_mux = {24'h0, lb_now, btn_any, coil_act, cfg_loaded_reg, 1'b0, state_reg};
		end else if (wb_adr_i == wmcc_pkg::ADR_CFG) begin
			rd_mux = {16'h0, cfg_reg};
		end else if (wb_adr_i == wmcc_pkg::ADR_NVM_IDX) begin
			rd_mux = {29'h0, nvm_idx_reg};
		end else if (wb_adr_i == wmcc_pkg::ADR_NVM_DATA) begin
			if (nvm_idx_reg >= wmcc_pkg::NVM_USER0) begin
				rd_mux = {16'h0, nvm_mem[nvm_idx_reg]};
			end
		end else if (wb_adr_i == wmcc_pkg::ADR_COUNT) begin
			rd_mux = {16'h0, cnt_bin};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= wb_req;
			dat_reg <= wb_req ? rd_mux : 32'h0000_0000;
		end
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	// Status and mode outputs, one cycle behind the state they show.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_power_o       <= 1'b0;
			encoder_mode_o     <= 1'b0;
			transponder_mode_o <= 1'b0;
			low_battery_flag_o <= 1'b0;
			coil_if_en_o       <= 1'b1;
			osc_trim_field_o   <= 4'h0;
			led_o              <= 1'b0;
		end else begin
			main_power_o       <= state_reg != wmcc_pkg::ST_STANDBY;
			encoder_mode_o     <= state_reg == wmcc_pkg::ST_COUNT
				|| state_reg == wmcc_pkg::ST_SEND;
			transponder_mode_o <= state_reg == wmcc_pkg::ST_XPOND;
			low_battery_flag_o <= lb_now;
			coil_if_en_o       <= ~pinsel_eff;
			osc_trim_field_o   <= cfg_reg[wmcc_pkg::CFG_TRIM_LSB +: 4];
			// A weak battery turns the steady lamp into a blink.
			led_o <= (state_reg == wmcc_pkg::ST_SEND) && (!lb_now || bit_cnt_reg[2]);
		end
	end

	// Pin drivers; an enable low means the pin is driven.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_pin_o                       <= 1'b0;
			data_pin_oe_n_o                  <= 1'b0;
			shared_button_rf_coil_pin_o      <= 1'b1;
			shared_button_rf_coil_pin_oe_n_o <= 1'b0;
		end else if (state_reg == wmcc_pkg::ST_PROG) begin
			data_pin_o                       <= shift_reg[15];
			data_pin_oe_n_o                  <= ~prog_rd;
			shared_button_rf_coil_pin_o      <= 1'b0;
			shared_button_rf_coil_pin_oe_n_o <= 1'b1;
		end else begin
			data_pin_oe_n_o <= 1'b0;
			data_pin_o      <= (state_reg == wmcc_pkg::ST_SEND)
				&& (shift_reg[31] ^ (cfg_reg[wmcc_pkg::CFG_MOD] & phase_reg));
			if (!pinsel_eff) begin
				shared_button_rf_coil_pin_o      <= 1'b1;
				shared_button_rf_coil_pin_oe_n_o <= 1'b0;
			end else begin
				shared_button_rf_coil_pin_o      <= encoder_mode_o;
				shared_button_rf_coil_pin_oe_n_o <= ~(state_reg == wmcc_pkg::ST_SEND);
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_wake;
		state_reg == wmcc_pkg::ST_STANDBY && wake_src && !prog_en;
	endsequence
	sequence s_up;
		state_reg == wmcc_pkg::ST_WAKE ##1 main_power_o;
	endsequence

	property p_standby_off;
		state_reg == wmcc_pkg::ST_STANDBY |=> !main_power_o;
	endproperty
	a_standby_off:
	assert property (p_standby_off) else $error("main power on in standby");

	property p_wake_up;
		s_wake |=> s_up;
	endproperty
	a_wake_up:
	assert property (p_wake_up) else $error("wake source did not power up");

	property p_btn_prio;
		state_reg == wmcc_pkg::ST_DECIDE && btn_any |=> state_reg == wmcc_pkg::ST_COUNT
			##1 encoder_mode_o;
	endproperty
	a_btn_prio:
	assert property (p_btn_prio) else $error("button did not win encoder mode");

	property p_coil_mode;
		state_reg == wmcc_pkg::ST_DECIDE && !btn_any && coil_act |=> ##1 transponder_mode_o;
	endproperty
	a_coil_mode:
	assert property (p_coil_mode) else $error("coil wake missed transponder mode");

	property p_cfg_load;
		state_reg == wmcc_pkg::ST_CFGLD |=> cfg_loaded_reg
			&& cfg_reg == $past(nvm_mem[wmcc_pkg::NVM_CFG]);
	endproperty
	a_cfg_load:
	assert property (p_cfg_load) else $error("configuration not loaded");

	property p_lb_high;
		lb_now |=> low_battery_flag_o;
	endproperty
	a_lb_high:
	assert property (p_lb_high) else $error("low battery flag not set");

	property p_lb_low;
		!lb_now |=> !low_battery_flag_o;
	endproperty
	a_lb_low:
	assert property (p_lb_low) else $error("low battery flag not clear");

	property p_pin_default;
		!cfg_loaded_reg && state_reg != wmcc_pkg::ST_PROG |=> !shared_button_rf_coil_pin_oe_n_o;
	endproperty
	a_pin_default:
	assert property (p_pin_default) else $error("third pin left coil role early");

	property p_no_write_low_v;
		!vpp |=> $stable(nvm_mem[wmcc_pkg::NVM_CNT]) && $stable(nvm_mem[wmcc_pkg::NVM_SEM]);
	endproperty
	a_no_write_low_v:
	assert property (p_no_write_low_v) else $error("write without write voltage");

	property p_secret_read;
		wb_req && !wb_we_i && wb_adr_i == wmcc_pkg::ADR_NVM_DATA
			&& nvm_idx_reg < wmcc_pkg::NVM_USER0 |=> wb_ack_o && wb_dat_o == 32'h0000_0000;
	endproperty
	a_secret_read:
	assert property (p_secret_read) else $error("secret word readable");

endmodule

// ==== include/wmcc_pkg.sv ====
// Package of constants, states and helpers for the wake-up, mode and configuration core.
package wmcc_pkg;

	// ****************************************
	// Clock and basic time element
	// ****************************************
	localparam int CLK_MHZ     = 50;
	localparam int TE_US       = 100;
	localparam int TE_CYC      = TE_US * CLK_MHZ;
	localparam int TE_STEP_CYC = TE_CYC / 64;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] ADR_CTRL     = 8'h00;
	localparam logic [7:0] ADR_STATUS   = 8'h04;
	localparam logic [7:0] ADR_CFG      = 8'h08;
	localparam logic [7:0] ADR_NVM_IDX  = 8'h0c;
	localparam logic [7:0] ADR_NVM_DATA = 8'h10;
	localparam logic [7:0] ADR_COUNT    = 8'h14;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int CTRL_PROG_EN = 0;
	localparam int CTRL_PROG_RD = 1;
	localparam int CFG_TRIM_LSB = 0;
	localparam int CFG_VSEL     = 4;
	localparam int CFG_PINSEL   = 5;
	localparam int CFG_MOD      = 6;
	localparam logic [15:0] CFG_RST  = 16'h0000;
	localparam logic [1:0]  CTRL_RST = 2'h0;

	// ****************************************
	// Nonvolatile word map
	// ****************************************
	localparam int          NVM_WORDS = 8;
	localparam logic [2:0]  NVM_CFG   = 3'h0;
	localparam logic [2:0]  NVM_CNT   = 3'h1;
	localparam logic [2:0]  NVM_SEM   = 3'h2;
	localparam logic [2:0]  NVM_USER0 = 3'h4;
	localparam logic [15:0] SEM_IDLE  = 16'h0000;
	localparam logic [15:0] SEM_BUSY  = 16'h5a5a;
	localparam logic [1:0]  CNT_STEPS = 2'h2;
	localparam logic [3:0]  PROG_LAST = 4'hf;

	// Gray code along standby, wake, load, decide, count, send.
	typedef enum logic [2:0] {
		ST_STANDBY = 3'h0,
		ST_WAKE    = 3'h1,
		ST_CFGLD   = 3'h3,
		ST_DECIDE  = 3'h2,
		ST_COUNT   = 3'h6,
		ST_SEND    = 3'h7,
		ST_XPOND   = 3'h5,
		ST_PROG    = 3'h4
	} wmcc_state_t;

	// Gray to binary, one prefix xor per bit.
	function automatic logic [15:0] gray2bin(input logic [15:0] g);
		logic [15:0] b;
		b[15] = g[15];
		for (int i = 14; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	function automatic logic [15:0] bin2gray(input logic [15:0] b);
		return b ^ {1'b0, b[15:1]};
	endfunction

endpackage

// ==== core/wmcc_sync3.sv ====
// Three-stage pin synchroniser whose output moves only when stages two and three agree.
`timescale 1ns/1ps

module wmcc_sync3 #(
	parameter int WIDTH = 1
) (
	input  logic             clk_i,
	input  logic             rst_i,
	input  logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] q_reg;

	// The first stage feeds only the second, so a metastable sample never reaches logic.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q_reg  <= '0;
		end else begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_reg  <= ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & q_reg);
		end
	end

	assign q_o = q_reg;

endmodule

// ==== bench/wmcc_far_end.sv ====
// Model of the buttons, reader field, battery sensors and programmer lines.
`timescale 1ns/1ps

module wmcc_far_end (
	input  wire logic clk_i,
	input  wire logic pin3_d_i,
	input  wire logic pin3_oe_n_i,
	input  wire logic dat_d_i,
	input  wire logic dat_oe_n_i,
	output logic      b0_o,
	output logic      b1_o,
	output logic      pin3_o,
	output logic      coil_o,
	output logic      dat_o,
	output logic      lo22_o,
	output logic      lo44_o,
	output logic      vpp_o
);
	logic       b2;
	logic [6:0] lv;
	logic       pd;

	// One level vector carries every switch and sensor line of the far side.
	assign {vpp_o, lo44_o, lo22_o, coil_o, b2, b1_o, b0_o} = lv;
	// When the device lets go of the third pin, it follows the third button level b2.
	assign pin3_o = pin3_oe_n_i ? b2 : pin3_d_i;
	// The programmer drives the data line whenever the device has let go of it.
	assign dat_o = dat_oe_n_i ? pd : dat_d_i;

	initial begin
		lv = 7'h40;
		pd = 1'b0;
	end

	// Levels change just after an edge, as a real switch would be sampled.
	task automatic set(input logic [6:0] v);
		@(posedge clk_i);
		lv <= v;
	endtask

	// Clocks one word in, first bit first; each level stands long enough to be synchronised.
	task automatic prog_word(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			@(posedge clk_i);
			pd <= w[i];
			repeat (4) @(posedge clk_i);
			lv[2] <= 1'b1;
			repeat (4) @(posedge clk_i);
			lv[2] <= 1'b0;
		end
	endtask
endmodule

// ==== bench/test_wakeup_mode_and_config_control.sv ====
// Self-checking bench for the wake-up, mode and configuration core.
`timescale 1ns/1ps

module test_wakeup_mode_and_config_control;
	logic        clk_i, rst_i, cyc, stb, we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, rd, q;
	wire         ack, b0, b1, p3, p3o, p3e, coil, di, dq, de, l22, l44, vpp;
	wire         led, pw, enc, xp, lbf, cen;
	wire  [3:0]  trim;
	int          bad_count, num_checks, cyc_cnt;

	wmcc_core #(.TE_CYC(64), .TE_STEP(1)) u_wmcc_core (.clk_i(clk_i), .rst_i(rst_i),
		.wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_dat_o(rd), .wb_ack_o(ack), .button_in_first_i(b0),
		.button_in_second_i(b1), .shared_button_rf_coil_pin_i(p3),
		.shared_button_rf_coil_pin_o(p3o), .shared_button_rf_coil_pin_oe_n_o(p3e),
		.coil_input_pin_i(coil), .data_pin_i(di), .data_pin_o(dq), .data_pin_oe_n_o(de),
		.lowbat_below_2v2_i(l22), .lowbat_below_4v4_i(l44), .nvm_vpp_ok_i(vpp),
		.led_o(led), .main_power_o(pw), .encoder_mode_o(enc), .transponder_mode_o(xp),
		.low_battery_flag_o(lbf), .coil_if_en_o(cen), .osc_trim_field_o(trim));

	wmcc_far_end u_wmcc_far_end (.clk_i(clk_i), .pin3_d_i(p3o), .pin3_oe_n_i(p3e),
		.dat_d_i(dq), .dat_oe_n_i(de), .b0_o(b0), .b1_o(b1), .pin3_o(p3), .coil_o(coil),
		.dat_o(di), .lo22_o(l22), .lo44_o(l44), .vpp_o(vpp));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask

	// Single classic cycle; waits for ack without assuming its latency.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rd;
		{cyc, stb, we} <= 3'b000;
	endtask

	function automatic logic sig(input int s);
		return s == 0 ? pw : s == 1 ? enc : s == 2 ? xp : s == 3 ? lbf : s == 4 ? dq : led;
	endfunction

	// Bounded wait for a level, then judged.
	task automatic wf(input int s, input logic v);
		int n;
		n = 0;
		while (sig(s) !== v && n < 6000) begin
			@(posedge clk_i);
			n++;
		end
		chk($sformatf("level %0d", s), {31'h0, v}, {31'h0, sig(s)});
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		chk("power", 0, pw);
		chk("pin3 role", 2'b01, {p3e, p3o});
		wb(1'b0, wmcc_pkg::ADR_STATUS, 0);
		chk("state", 0, q[2:0]);
		$display("test reset done");
	endtask

	// Programs the configuration word: trim 3, threshold select 1, coil role kept.
	task automatic t_prog();
		wb(1'b1, wmcc_pkg::ADR_CTRL, 1);
		wb(1'b0, wmcc_pkg::ADR_STATUS, 0);
		chk("prog state", 4, q[2:0]);
		chk("pin3 released", 1, p3e);
		chk("data released", 1, de);
		u_wmcc_far_end.prog_word(16'h0013);
		wb(1'b1, wmcc_pkg::ADR_CTRL, 3);
		repeat (2) @(posedge clk_i);
		chk("data driven", 0, de);
		wb(1'b1, wmcc_pkg::ADR_CTRL, 0);
		wb(1'b0, wmcc_pkg::ADR_STATUS, 0);
		chk("prog left", 0, q[2:0]);
		$display("test programming done");
	endtask

	task automatic t_button();
		u_wmcc_far_end.set(7'h51);
		wf(0, 1'b1);
		wf(1, 1'b1);
		chk("xpond", 0, xp);
		chk("trim", 3, trim);
		chk("coil en", 1, cen);
		repeat (8) @(posedge clk_i);
		chk("lamp steady", 1, led);
		chk("low 2v2 unused", 0, lbf);
		wf(4, 1'b1);
		u_wmcc_far_end.set(7'h61);
		wf(3, 1'b1);
		wf(5, 1'b0);
		wb(1'b0, wmcc_pkg::ADR_STATUS, 0);
		chk("cfg loaded", 1, q[4]);
		wb(1'b0, wmcc_pkg::ADR_CFG, 0);
		chk("cfg word", 32'h13, q);
		u_wmcc_far_end.set(7'h40);
		wf(3, 1'b0);
		wf(0, 1'b0);
		wb(1'b0, wmcc_pkg::ADR_COUNT, 0);
		chk("count", 1, q);
		$display("test button done");
	endtask

	task automatic t_prio();
		u_wmcc_far_end.set(7'h49);
		wf(1, 1'b1);
		repeat (20) @(posedge clk_i);
		chk("xpond held", 0, xp);
		u_wmcc_far_end.set(7'h48);
		wf(2, 1'b1);
		chk("enc off", 0, enc);
		u_wmcc_far_end.set(7'h40);
		wf(0, 1'b0);
		wb(1'b0, wmcc_pkg::ADR_COUNT, 0);
		chk("count", 2, q);
		$display("test priority done");
	endtask

	task automatic t_nvm();
		wb(1'b1, wmcc_pkg::ADR_NVM_IDX, 4);
		wb(1'b1, wmcc_pkg::ADR_NVM_DATA, 32'h1234);
		wb(1'b0, wmcc_pkg::ADR_NVM_DATA, 0);
		chk("user word", 32'h1234, q);
		u_wmcc_far_end.set(7'h00);
		repeat (6) @(posedge clk_i);
		wb(1'b1, wmcc_pkg::ADR_NVM_DATA, 32'h5678);
		wb(1'b0, wmcc_pkg::ADR_NVM_DATA, 0);
		chk("no vpp", 32'h1234, q);
		wb(1'b1, wmcc_pkg::ADR_NVM_IDX, 3);
		wb(1'b0, wmcc_pkg::ADR_NVM_DATA, 0);
		chk("secret", 0, q);
		sel <= 4'h0;
		wb(1'b1, wmcc_pkg::ADR_NVM_IDX, 5);
		sel <= 4'hf;
		wb(1'b0, wmcc_pkg::ADR_NVM_IDX, 0);
		chk("masked index", 3, q);
		wb(1'b0, 8'h20, 0);
		chk("unmapped", 0, q);
		$display("test storage done");
	endtask

	// ****************************************
	// Clock, reset, timeout and sequence
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// A hang is cut short well beyond the longest expected run.
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 60000) begin
			bad_count++;
			summarize();
		end
	end

	initial begin
		{rst_i, cyc, stb, we, adr, dat} = {4'b1000, 8'h00, 32'h0};
		sel = 4'hf;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_prog();
		t_button();
		t_prio();
		t_nvm();
		summarize();
	end
endmodule
